/* File: rtl/sgx_executor.sv */
// Overview of operation
// - Delay command waits requested milliseconds
// - Line config changes one direction bit
// - Port map: one output, zero input
// - Port config updates all eight lines
// - Line read samples one selected line
// - Sample reads 0 low, 1 high
// - Result stored at read command's index
// - Port write changes output lines only
`timescale 1ns/100ps
`default_nettype none
module sgx_executor (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [7:0] i_gpl_in,
	output logic [7:0] o_gpl_out,
	output logic [7:0] o_gpl_oe_n
);
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] dir_r;
	logic [7:0] dir_nxt;
	logic [7:0] out_r;
	logic [7:0] out_nxt;
	logic [0:0] slot_r [0:sgx_pkg::SLOTS-1];
	logic [sgx_pkg::SLOT_AW-1:0] idx_r;
	logic [sgx_pkg::SLOT_AW-1:0] idx_nxt;
	logic slot_we;
	logic [sgx_pkg::ARG_W-1:0] ms_r;
	logic [sgx_pkg::ARG_W-1:0] ms_nxt;
	logic [31:0] cyc_r;
	logic [31:0] cyc_nxt;
	sgx_pkg::sgx_state_t st_r;
	sgx_pkg::sgx_state_t st_nxt;
	logic bad_r;
	logic bad_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [31:0] rd_r;
	logic [31:0] rd_nxt;
	logic req;
	logic wr_cmd;
	logic busy;
	logic [3:0] op;
	logic [2:0] line;
	logic [7:0] val;

	// Ack gating keeps one request from being taken twice
	assign req = i_wb_cyc && i_wb_stb && !ack_r;
	assign busy = st_r == sgx_pkg::SGX_WAIT;
	assign wr_cmd = req && i_wb_we && i_wb_sel[0]
		&& i_wb_adr == sgx_pkg::ADDR_CMD;
	assign op = i_wb_dat[sgx_pkg::OP_LSB +: 4];
	assign line = i_wb_dat[sgx_pkg::LINE_LSB +: 3];
	assign val = i_wb_dat[sgx_pkg::VAL_LSB +: 8];

	always_comb begin
		st_nxt = st_r;
		dir_nxt = dir_r;
		out_nxt = out_r;
		idx_nxt = idx_r;
		ms_nxt = ms_r;
		cyc_nxt = cyc_r;
		bad_nxt = bad_r;
		slot_we = 1'b0;
		ack_nxt = 1'b0;
		// Reads and control writes still answer during a delay
		if (req) begin
			ack_nxt = !(wr_cmd && busy);
		end
		unique case (st_r)
			sgx_pkg::SGX_WAIT: begin
				if (cyc_r == sgx_pkg::MS_CYCLES - 1) begin
					cyc_nxt = '0;
					ms_nxt = ms_r - 1'b1;
					if (ms_r == 1) begin
						st_nxt = sgx_pkg::SGX_DONE;
					end
				end else begin
					cyc_nxt = cyc_r + 1'b1;
				end
			end
			// Done lasts one cycle; busy is already low, so a stalled command is taken here
			sgx_pkg::SGX_DONE: begin
				st_nxt = sgx_pkg::SGX_IDLE;
			end
			default: begin
			end
		endcase
		if (wr_cmd && !busy) begin
			unique case (op)
				sgx_pkg::OP_DELAY: begin
					ms_nxt = i_wb_dat[sgx_pkg::ARG_W-1:0];
					cyc_nxt = '0;
					// Zero milliseconds means no wait at all
					if (i_wb_dat[sgx_pkg::ARG_W-1:0] != '0) begin
						st_nxt = sgx_pkg::SGX_WAIT;
					end
				end
				sgx_pkg::OP_CFG_LINE: begin
					dir_nxt[line] = val[0];
				end
				sgx_pkg::OP_CFG_PORT: begin
					dir_nxt = val;
				end
				sgx_pkg::OP_READ_LINE: begin
					slot_we = 1'b1;
					idx_nxt = idx_r + 1'b1;
				end
				sgx_pkg::OP_WRITE_PORT: begin
					out_nxt = (out_r & ~dir_r) | (val & dir_r);
				end
				// Unknown opcode: acked, but flagged in status
				default: begin
					bad_nxt = 1'b1;
				end
			endcase
		end
		// Index wraps; old slots are overwritten
		if (req && i_wb_we && i_wb_sel[0]) begin
			if (i_wb_adr == sgx_pkg::ADDR_CTRL
				&& i_wb_dat[sgx_pkg::CTRL_CLR_IDX]) begin
				idx_nxt = '0;
				bad_nxt = 1'b0;
			end
		end
	end

	// Read data comes only from registers, never straight from a pin
	always_comb begin
		rd_nxt = rd_r;
		if (req && !i_wb_we) begin
			rd_nxt = '0;
			if (i_wb_adr == sgx_pkg::ADDR_STAT) begin
				rd_nxt[sgx_pkg::STAT_BUSY] = busy;
				rd_nxt[sgx_pkg::STAT_BAD] = bad_r;
				rd_nxt[8 +: sgx_pkg::SLOT_AW] = idx_r;
			end else if (i_wb_adr == sgx_pkg::ADDR_DIR) begin
				rd_nxt[7:0] = dir_r;
			end else if (i_wb_adr == sgx_pkg::ADDR_OUT) begin
				rd_nxt[7:0] = out_r;
			end else if (i_wb_adr == sgx_pkg::ADDR_PIN) begin
				rd_nxt[7:0] = sync2_r;
			end else if (i_wb_adr[7:6] == sgx_pkg::ADDR_SLOT[7:6]) begin
				rd_nxt[0] = slot_r[i_wb_adr[sgx_pkg::SLOT_LSB +:
					sgx_pkg::SLOT_AW]];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= sgx_pkg::SGX_IDLE;
			dir_r <= 8'h00;
			out_r <= 8'h00;
			idx_r <= '0;
			ms_r <= '0;
			cyc_r <= '0;
			bad_r <= 1'b0;
			ack_r <= 1'b0;
		end else if (i_ce) begin
			st_r <= st_nxt;
			dir_r <= dir_nxt;
			out_r <= out_nxt;
			idx_r <= idx_nxt;
			ms_r <= ms_nxt;
			cyc_r <= cyc_nxt;
			bad_r <= bad_nxt;
			ack_r <= ack_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_r <= '0;
		end else if (i_ce) begin
			rd_r <= rd_nxt;
		end
	end

	// Pins are asynchronous; only the second flop is read
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else if (i_ce) begin
			sync1_r <= i_gpl_in;
			sync2_r <= sync1_r;
		end
	end

	// Slots hold no reset; stale data is harmless once index is cleared
	always_ff @(posedge i_clk) begin
		if (i_ce && slot_we) begin
			slot_r[idx_r] <= sync2_r[line];
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rd_r;
	assign o_gpl_out = out_r;
	// Enable is active low: a direction one drives the line
	assign o_gpl_oe_n = ~dir_r;
endmodule : sgx_executor
`default_nettype wire

/* File: inc/sgx_pkg.sv */
package sgx_pkg;
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned DELAY_UNIT_MS = 1;
	// Cycles per millisecond, derived from the clock rate
	localparam int unsigned MS_CYCLES = (CLK_HZ / 1000) * DELAY_UNIT_MS;
	localparam int unsigned NUM_PORTS = 1;
	localparam int unsigned PORT_W = 8;
	localparam int unsigned SLOTS = 16;
	localparam int unsigned SLOT_AW = 4;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_DIR = 8'h0c;
	localparam logic [7:0] ADDR_OUT = 8'h10;
	localparam logic [7:0] ADDR_PIN = 8'h14;
	localparam logic [7:0] ADDR_SLOT = 8'h40;
	localparam int unsigned SLOT_LSB = 2;

	// Command word fields
	localparam int unsigned OP_LSB = 28;
	localparam int unsigned LINE_LSB = 8;
	localparam int unsigned VAL_LSB = 0;
	localparam int unsigned ARG_W = 16;
	localparam logic [3:0] OP_DELAY = 4'h1;
	localparam logic [3:0] OP_CFG_LINE = 4'h2;
	localparam logic [3:0] OP_CFG_PORT = 4'h3;
	localparam logic [3:0] OP_READ_LINE = 4'h4;
	localparam logic [3:0] OP_WRITE_PORT = 4'h5;

	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_BAD = 1;
	localparam int unsigned CTRL_CLR_IDX = 0;

	typedef enum logic [2:0] {
		SGX_IDLE = 3'b001,
		SGX_WAIT = 3'b010,
		SGX_DONE = 3'b100
	} sgx_state_t;
endpackage : sgx_pkg

/* File: sim/sgx_executor_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module sgx_executor_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [7:0] o_gpl_out,
	input wire logic [7:0] o_gpl_oe_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic cw;
	logic [3:0] op;
	assign cw = o_wb_ack && i_wb_we && i_wb_adr == sgx_pkg::ADDR_CMD;
	assign op = i_wb_dat[31:28];
	property p_rin; $fell(i_rst) |-> o_gpl_oe_n == 8'hff; endproperty
	a_rin: assert property (p_rin) else $error("dir reset");
	property p_ack; o_wb_ack |=> !o_wb_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack long");
	property p_req; o_wb_ack |-> $past(i_wb_cyc && i_wb_stb); endproperty
	a_req: assert property (p_req) else $error("ack cause");
	property p_kin;
		((o_gpl_out ^ $past(o_gpl_out)) & $past(o_gpl_oe_n)) == 8'h00;
	endproperty
	a_kin: assert property (p_kin) else $error("input driven");
	property p_dsrc; $changed(o_gpl_oe_n) |-> cw || $past(cw); endproperty
	a_dsrc: assert property (p_dsrc) else $error("dir cause");
	property p_line; cw && op == sgx_pkg::OP_CFG_LINE |=>
		((o_gpl_oe_n ^ $past(o_gpl_oe_n, 2)) & ~(8'h01 << i_wb_dat[10:8]))
		== 8'h00 && o_gpl_oe_n[i_wb_dat[10:8]] == !i_wb_dat[0];
	endproperty
	a_line: assert property (p_line) else $error("line dir");
	property p_port; cw && op == sgx_pkg::OP_CFG_PORT |=>
		o_gpl_oe_n == ~i_wb_dat[7:0];
	endproperty
	a_port: assert property (p_port) else $error("port dir");
	// Next command must stall for at least 8 cycles after a running delay starts
	property p_dly; cw && op == sgx_pkg::OP_DELAY &&
		i_wb_dat[15:0] != 16'h0000 |=> !cw [*8];
	endproperty
	a_dly: assert property (p_dly) else $error("delay skipped");
endmodule : sgx_executor_chk
bind sgx_executor sgx_executor_chk sgx_executor_chk_i (.*);
`default_nettype wire

/* File: sim/sgx_line_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sgx_line_model (
	input wire logic [7:0] i_ext,
	input wire logic [7:0] i_out,
	input wire logic [7:0] i_oe_n,
	output logic [7:0] o_pin
);
	// Undriven lines follow the outside source
	assign o_pin = (i_out & ~i_oe_n) | (i_ext & i_oe_n);
endmodule : sgx_line_model
`default_nettype wire

/* File: sim/sgx_executor_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module sgx_executor_bench;
	localparam logic [7:0] CMD = sgx_pkg::ADDR_CMD;
	logic i_clk = 0, i_rst = 1, i_ce = 1, i_wb_cyc = 0, i_wb_we = 0, o_wb_ack;
	logic [7:0] i_wb_adr = 0, ext = 8'h20, i_gpl_in, o_gpl_out, o_gpl_oe_n;
	logic [31:0] i_wb_dat = 0, o_wb_dat, q;
	logic [3:0] i_wb_sel = 4'hf;
	wire logic i_wb_stb = i_wb_cyc;
	int fails = 0, n_tests = 0, cnt = 0, t0;
	sgx_executor sgx_executor_i (.*);
	sgx_line_model sgx_line_model_i (.i_ext(ext), .i_out(o_gpl_out),
		.i_oe_n(o_gpl_oe_n), .o_pin(i_gpl_in));
	initial forever #2.5 i_clk = ~i_clk;
	always @(posedge i_clk) cnt <= cnt + 1;
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wb_cyc <= 1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= d;
		@(posedge i_clk);
		while (o_wb_ack !== 1'b1) @(posedge i_clk);
		q = o_wb_dat;
		i_wb_cyc <= 0;
	endtask : bus
	task chk(input string n, input logic [7:0] s, e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task print_verdict;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 0;
		chk("rst", o_gpl_oe_n, 8'hff);
		bus(1, CMD, 32'h3000000f);
		repeat (2) @(posedge i_clk);
		chk("port", o_gpl_oe_n, 8'hf0);
		bus(1, CMD, 32'h20000601);
		bus(1, CMD, 32'h500000ff);
		repeat (2) @(posedge i_clk);
		chk("line", o_gpl_oe_n, 8'hb0);
		chk("out", o_gpl_out, 8'h4f);
		$display("direction done");
		for (int i = 0; i < 8; i++) bus(1, CMD, 32'h40000000 | (i << 8));
		for (int i = 0; i < 8; i++) begin
			bus(0, 8'h40 + 8'(4 * i), 0);
			chk("slot", q[7:0], (8'h6f >> i) & 8'h01);
		end
		bus(0, 8'h3c, 0);
		chk("unmapped", q[7:0], 8'h00);
		bus(1, CMD, 32'h70000000);
		bus(0, sgx_pkg::ADDR_STAT, 0);
		chk("bad", q[7:0], 8'h02);
		chk("index", {4'h0, q[11:8]}, 8'h08);
		bus(1, sgx_pkg::ADDR_CTRL, 32'h00000001);
		bus(0, sgx_pkg::ADDR_STAT, 0);
		chk("clear", q[7:0] | q[11:8], 8'h00);
		bus(1, CMD, 32'h10000000);
		bus(0, sgx_pkg::ADDR_STAT, 0);
		chk("nodelay", q[7:0], 8'h00);
		// A full millisecond is too long to run; reset cuts it short
		bus(1, CMD, 32'h10000001);
		t0 = cnt;
		bus(0, sgx_pkg::ADDR_STAT, 0);
		chk("busy", q[7:0], 8'h01);
		repeat (20000) @(posedge i_clk);
		bus(0, sgx_pkg::ADDR_STAT, 0);
		chk("busy2", q[7:0], 8'h01);
		chk("span", {7'h0, cnt - t0 < sgx_pkg::MS_CYCLES}, 8'h01);
		i_rst <= 1;
		repeat (3) @(posedge i_clk);
		i_rst <= 0;
		chk("rst2", o_gpl_oe_n, 8'hff);
		bus(0, sgx_pkg::ADDR_STAT, 0);
		chk("idle", q[7:0], 8'h00);
		bus(1, CMD, 32'h40000500);
		bus(0, 8'h40, 0);
		chk("slot0", q[7:0], 8'h01);
		$display("delay done");
		print_verdict();
	end
	initial begin
		#250000;
		fails++;
		print_verdict();
	end
endmodule : sgx_executor_bench
`default_nettype wire
